// ### hdl/uecc_pkg.sv
// uecc_pkg: constants and carrier types for the channel command/enable control block.
// assumes one 100 MHz clock domain shared by all users of these types.
package uecc_pkg;

    // ------------------------------------------------------------------
    // command register layout
    // ------------------------------------------------------------------
    localparam int unsigned CMD_LOCK_BIT   = 7;
    localparam int unsigned CMD_TX_EN_BIT  = 6;
    localparam int unsigned CMD_RX_EN_BIT  = 5;
    localparam int unsigned CMD_CODE_W     = 5;
    localparam logic [7:0]  CMD_OFFSET     = 8'h12;
    localparam logic        TX_EN_RESET    = 1'b0;
    localparam logic        RX_EN_RESET    = 1'b0;
    localparam int unsigned BUF_DEPTH      = 2;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] data;
    } uecc_bus_t;

    typedef enum logic [1:0] {
        UECC_TX_OFF,
        UECC_TX_RUN,
        UECC_TX_DRAIN
    } uecc_tx_state_t;

    typedef struct packed {
        logic                  rst_s1;
        logic                  rst_s2;
        logic                  tx_en;
        logic                  rx_en;
        uecc_tx_state_t        tx_st;
        logic                  tx_ready;
        logic                  tx_idle;
        logic                  tx_act;
        logic                  q_valid;
        logic                  rx_active;
        logic                  rx_flush;
        logic [CMD_CODE_W-1:0] cmd_code;
        logic                  cmd_stb;
        logic [1:0][7:0]       buf_data;
        logic [1:0]            buf_cnt;
        logic                  buf_rd;
    } uecc_state_t;

endpackage : uecc_pkg

// ### hdl/uecc_top.sv
// uecc_top: command register write port with transmitter/receiver enable control,
// and a two-entry buffer in the received-data path toward the receive queue.
// assumes bus signals and transmitter/receiver status come from logic on CLOCK_IN.
`timescale 1ns/1ps
module uecc_top
    import uecc_pkg::*;
(
    input  wire logic                  CLOCK_IN,
    input  wire logic                  RSTN_IN,
    input  wire logic                  BUS_WR_IN,
    input  wire logic [7:0]            BUS_ADDR_IN,
    input  wire logic [7:0]            BUS_DATA_IN,
    input  wire logic                  TX_BUSY_IN,
    input  wire logic                  TX_QUEUE_EMPTY_IN,
    input  wire logic                  WAKEUP_MODE_IN,
    input  wire logic                  RX_CHAR_VALID_IN,
    input  wire logic [7:0]            RX_CHAR_IN,
    output logic                       RX_CHAR_READY_OUT,
    input  wire logic                  RX_QUEUE_READY_IN,
    output logic                       RX_QUEUE_VALID_OUT,
    output logic [7:0]                 RX_QUEUE_DATA_OUT,
    output logic                       TX_ENABLE_OUT,
    output logic                       RX_ENABLE_OUT,
    output logic                       TX_ACTIVE_OUT,
    output logic                       TRANSMIT_READY_FLAG_OUT,
    output logic                       TX_IDLE_FLAG_OUT,
    output logic                       RX_ACTIVE_OUT,
    output logic                       RX_FLUSH_OUT,
    output logic                       CMD_STROBE_OUT,
    output logic [CMD_CODE_W-1:0]      CMD_CODE_OUT
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    uecc_state_t s_q;
    uecc_state_t s_d;
    uecc_bus_t   bus;
    logic        rst_n;
    logic        hit;
    logic        push;
    logic        pop;

    assign bus   = '{wr: BUS_WR_IN, addr: BUS_ADDR_IN, data: BUS_DATA_IN};
    assign rst_n = s_q.rst_s2;
    assign hit   = bus.wr && (bus.addr == CMD_OFFSET);
    // a word moves only on the ready already shown to the receiver, so both
    // sides agree on every transfer; a stalled queue backs up to the receiver
    assign push  = RX_CHAR_VALID_IN && s_q.buf_rd;
    assign pop   = s_q.q_valid && RX_QUEUE_READY_IN;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d         = s_q;
        s_d.rst_s1  = 1'b1;
        s_d.rst_s2  = s_q.rst_s1;
        s_d.cmd_stb = 1'b0;
        s_d.rx_flush = 1'b0;

        // ------------------------------------------------------------------
        // command write
        // ------------------------------------------------------------------
        if (hit) begin
            s_d.cmd_code = bus.data[CMD_CODE_W-1:0];
            s_d.cmd_stb  = 1'b1;
            if (bus.data[CMD_LOCK_BIT]) begin
                s_d.tx_en = bus.data[CMD_TX_EN_BIT];
                s_d.rx_en = bus.data[CMD_RX_EN_BIT];
            end                                                  // else kept
        end

        // ------------------------------------------------------------------
        // transmitter
        // ------------------------------------------------------------------
        // disable only changes flags, never resets the transmit queue
        unique case (s_q.tx_st)
            UECC_TX_OFF: begin
                if (s_d.tx_en) begin
                    s_d.tx_st = UECC_TX_RUN;
                end
            end
            UECC_TX_RUN: begin
                if (!s_d.tx_en) begin
                    // pending characters go out first
                    s_d.tx_st = (TX_BUSY_IN || !TX_QUEUE_EMPTY_IN) ? UECC_TX_DRAIN
                                                                   : UECC_TX_OFF;
                end
            end
            UECC_TX_DRAIN: begin
                if (s_d.tx_en) begin
                    s_d.tx_st = UECC_TX_RUN;
                end else if (!TX_BUSY_IN && TX_QUEUE_EMPTY_IN) begin
                    s_d.tx_st = UECC_TX_OFF;
                end
            end
            default: begin
                // unused encoding; fall back to the quiet state
                s_d.tx_st = UECC_TX_OFF;
            end
        endcase
        s_d.tx_act   = (s_d.tx_st != UECC_TX_OFF);
        s_d.tx_ready = s_d.tx_en;
        s_d.tx_idle  = s_d.tx_en && !TX_BUSY_IN && TX_QUEUE_EMPTY_IN;

        // ------------------------------------------------------------------
        // receiver
        // ------------------------------------------------------------------
        // runs at once on enable, or under wake-up mode
        s_d.rx_active = s_d.rx_en || WAKEUP_MODE_IN;
        if (s_q.rx_active && !s_d.rx_active) begin
            s_d.rx_flush = 1'b1;                                 // partial char dropped
        end

        // ------------------------------------------------------------------
        // receive buffer
        // ------------------------------------------------------------------
        // contents survive a disable; new words go behind them
        unique case ({push, pop})
            2'b10: begin
                if (s_q.buf_cnt == 2'h0) begin
                    s_d.buf_data[0] = RX_CHAR_IN;
                end else begin
                    s_d.buf_data[1] = RX_CHAR_IN;
                end
                s_d.buf_cnt = s_q.buf_cnt + 2'h1;
            end
            2'b01: begin
                s_d.buf_data[0] = s_q.buf_data[1];
                s_d.buf_cnt     = s_q.buf_cnt - 2'h1;
            end
            2'b11: begin
                // head leaves as the new word arrives; count stays
                if (s_q.buf_cnt == 2'h1) begin
                    s_d.buf_data[0] = RX_CHAR_IN;
                end else begin
                    s_d.buf_data[0] = s_q.buf_data[1];
                    s_d.buf_data[1] = RX_CHAR_IN;
                end
            end
            2'b00: begin
            end
        endcase
        s_d.q_valid = (s_d.buf_cnt != 2'h0);
        // ready is registered, so it is worked out from next cycle's count and
        // mode; after a disable ready drops in the same cycle as RX_ACTIVE_OUT
        s_d.buf_rd  = s_d.rx_active && (s_d.buf_cnt != 2'(BUF_DEPTH));
    end

    // ------------------------------------------------------------------
    // registers; the raw reset clears all of them, the synchronised reset all but the synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            s_q       <= '0;
            s_q.tx_en <= TX_EN_RESET;
            s_q.rx_en <= RX_EN_RESET;
            s_q.tx_st <= UECC_TX_OFF;
        end else if (!rst_n) begin
            s_q        <= '0;
            s_q.rst_s1 <= 1'b1;
            s_q.rst_s2 <= s_q.rst_s1;
            s_q.tx_st  <= UECC_TX_OFF;
        end else begin
            s_q <= s_d;
        end
    end

    assign RX_CHAR_READY_OUT       = s_q.buf_rd;
    // ------------------------------------------------------------------
    // outputs, all straight from the state register
    // ------------------------------------------------------------------
    assign RX_QUEUE_VALID_OUT      = s_q.q_valid;
    assign RX_QUEUE_DATA_OUT       = s_q.buf_data[0];
    assign TX_ENABLE_OUT           = s_q.tx_en;
    assign RX_ENABLE_OUT           = s_q.rx_en;
    assign TX_ACTIVE_OUT           = s_q.tx_act;
    assign TRANSMIT_READY_FLAG_OUT = s_q.tx_ready;
    assign TX_IDLE_FLAG_OUT        = s_q.tx_idle;
    assign RX_ACTIVE_OUT           = s_q.rx_active;
    assign RX_FLUSH_OUT            = s_q.rx_flush;
    assign CMD_STROBE_OUT          = s_q.cmd_stb;
    assign CMD_CODE_OUT            = s_q.cmd_code;

endmodule // uecc_top

// ### bench/uecc_monitor.sv
// checker: enable, flag and strobe relations at the uecc_top ports
// assumes it is bound onto uecc_top; one clock domain
`timescale 1ns/1ps
module uecc_monitor
    import uecc_pkg::*;
(
    input wire logic CLOCK_IN, RSTN_IN, BUS_WR_IN, TX_BUSY_IN, TX_QUEUE_EMPTY_IN,
    input wire logic WAKEUP_MODE_IN, TX_ENABLE_OUT, RX_ENABLE_OUT, TX_ACTIVE_OUT,
    input wire logic RX_ACTIVE_OUT, TRANSMIT_READY_FLAG_OUT, TX_IDLE_FLAG_OUT,
    input wire logic RX_FLUSH_OUT, CMD_STROBE_OUT,
    input wire logic [7:0] BUS_ADDR_IN, BUS_DATA_IN,
    input wire logic [CMD_CODE_W-1:0] CMD_CODE_OUT
);
    default clocking @(posedge CLOCK_IN); endclocking
    default disable iff (!RSTN_IN);
    wire       wr = BUS_WR_IN && (BUS_ADDR_IN == CMD_OFFSET);
    wire [7:0] d  = BUS_DATA_IN;
    sequence rx_drop;
        !RX_ACTIVE_OUT && RX_FLUSH_OUT ##1 !RX_FLUSH_OUT;
    endsequence
    lock_hold_a: assert property (
        wr && !d[7] |=> $stable(TX_ENABLE_OUT) && $stable(RX_ENABLE_OUT))
        else $error("enable bits moved on a locked write");
    lock_load_a: assert property (
        wr && d[7] |=> {TX_ENABLE_OUT, RX_ENABLE_OUT} == $past(d[6:5]))
        else $error("enable bits not loaded");
    tx_start_a: assert property (
        wr && d[7] && d[6] |=> TRANSMIT_READY_FLAG_OUT && TX_ACTIVE_OUT)
        else $error("transmitter did not start");
    tx_stop_a: assert property (
        wr && d[7] && !d[6] |=> !TRANSMIT_READY_FLAG_OUT && !TX_IDLE_FLAG_OUT)
        else $error("transmit flags kept after disable");
    tx_drain_a: assert property (
        TX_ACTIVE_OUT && (TX_BUSY_IN || !TX_QUEUE_EMPTY_IN) |=> TX_ACTIVE_OUT)
        else $error("transmitter stopped with work pending");
    rx_start_a: assert property (
        wr && d[7] && d[5] |=> RX_ACTIVE_OUT)
        else $error("receiver did not start");
    rx_stop_a: assert property (
        wr && d[7] && !d[5] && RX_ENABLE_OUT && !WAKEUP_MODE_IN |=> rx_drop)
        else $error("receiver stop or flush wrong");
    wake_run_a: assert property (
        WAKEUP_MODE_IN |=> RX_ACTIVE_OUT)
        else $error("receiver idle in wake-up mode");
    cmd_strobe_a: assert property (
        wr |=> CMD_STROBE_OUT && CMD_CODE_OUT == $past(d[4:0]))
        else $error("command strobe or code wrong");
endmodule // uecc_monitor
bind uecc_top uecc_monitor u_mon (.CLOCK_IN, .RSTN_IN, .BUS_WR_IN, .TX_BUSY_IN,
    .TX_QUEUE_EMPTY_IN, .WAKEUP_MODE_IN, .TX_ENABLE_OUT, .RX_ENABLE_OUT, .TX_ACTIVE_OUT,
    .RX_ACTIVE_OUT, .TRANSMIT_READY_FLAG_OUT, .TX_IDLE_FLAG_OUT, .RX_FLUSH_OUT,
    .CMD_STROBE_OUT, .BUS_ADDR_IN, .BUS_DATA_IN, .CMD_CODE_OUT);

// ### bench/uecc_rx_sink.sv
// partner: receive queue sink that pulls words out of the rx buffer
// assumes the bench drives stall_in off the rising edge
`timescale 1ns/1ps
module uecc_rx_sink (
    input  wire logic       clk_in,
    input  wire logic       stall_in,
    input  wire logic       valid_in,
    input  wire logic [7:0] data_in,
    output logic            ready_out
);
    logic [7:0] got_q[$];
    assign ready_out = !stall_in;
    always @(posedge clk_in)
        if (valid_in && ready_out) got_q.push_back(data_in);
endmodule // uecc_rx_sink

// ### bench/tb_uart_enable_command_control.sv
// testbench: command writes and rx buffer traffic for uecc_top
// assumes monitor and sink model are compiled before it
`timescale 1ns/1ps
module tb_uart_enable_command_control;
    import uecc_pkg::*;
    logic clk = 0, rstn = 0, wr = 0, busy = 0, empty = 1, wake = 0, cv = 0, stall = 1;
    logic crdy, qv, qrdy, txe, rxe, txa, rdy, idle, rxa, fl, stb;
    logic [7:0] addr = 0, din = 0, ch = 0, qd;
    logic [4:0] code;
    int err_total = 0, n_checks = 0, cyc = 0;
    uecc_top DUT (.CLOCK_IN(clk), .RSTN_IN(rstn), .BUS_WR_IN(wr), .BUS_ADDR_IN(addr),
        .BUS_DATA_IN(din), .TX_BUSY_IN(busy), .TX_QUEUE_EMPTY_IN(empty),
        .WAKEUP_MODE_IN(wake), .RX_CHAR_VALID_IN(cv), .RX_CHAR_IN(ch),
        .RX_CHAR_READY_OUT(crdy), .RX_QUEUE_READY_IN(qrdy), .RX_QUEUE_VALID_OUT(qv),
        .RX_QUEUE_DATA_OUT(qd), .TX_ENABLE_OUT(txe), .RX_ENABLE_OUT(rxe),
        .TX_ACTIVE_OUT(txa), .TRANSMIT_READY_FLAG_OUT(rdy), .TX_IDLE_FLAG_OUT(idle),
        .RX_ACTIVE_OUT(rxa), .RX_FLUSH_OUT(fl), .CMD_STROBE_OUT(stb), .CMD_CODE_OUT(code));
    uecc_rx_sink sink (.clk_in(clk), .stall_in(stall), .valid_in(qv), .data_in(qd),
        .ready_out(qrdy));
    initial forever #5 clk = ~clk;
    // run takes under 40 cycles; ceiling well above that
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            stop_test();
        end
    end
    task automatic chk(input logic [7:0] g, e);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, d);
        @(negedge clk);
        wr = 1;
        addr = a;
        din = d;
        @(negedge clk);
        wr = 0;
    endtask
    task automatic push(input logic [7:0] c);
        @(negedge clk);
        cv = 1;
        ch = c;
        while (crdy !== 1'b1) @(negedge clk);
        @(negedge clk);
        cv = 0;
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge clk);
        rstn = 1;
        repeat (3) @(negedge clk);
        wr_reg(CMD_OFFSET, 8'he0);
        chk({txe, rxe, rdy, idle, rxa, stb}, 8'h3f);
        wr_reg(CMD_OFFSET, 8'h04);
        chk({txe, rxe, stb, code}, 8'he4);
        wr_reg(8'h13, 8'h80);
        chk({txe, rxe, stb}, 8'h06);
        busy = 1;
        wr_reg(CMD_OFFSET, 8'ha0);
        chk({rdy, idle, txa, rxe}, 8'h03);
        busy = 0;
        repeat (3) @(negedge clk);
        chk(txa, 8'h00);
        push(8'h5a);
        push(8'h3c);
        chk({qv, crdy}, 8'h02);
        chk(qd, 8'h5a);
        wr_reg(CMD_OFFSET, 8'h80);
        chk({rxa, rxe, fl, qv}, 8'h03);
        wr_reg(CMD_OFFSET, 8'ha0);
        stall = 0;
        push(8'h77);
        repeat (4) @(negedge clk);
        chk(8'(sink.got_q.size()), 8'h03);
        chk(sink.got_q[0], 8'h5a);
        chk(sink.got_q[2], 8'h77);
        wr_reg(CMD_OFFSET, 8'h80);
        wake = 1;
        repeat (2) @(negedge clk);
        chk({rxa, rxe}, 8'h02);
        stop_test();
    end
endmodule // tb_uart_enable_command_control
